//--- core/ipf_pkg.sv
`default_nettype none

package ipf_pkg;

    localparam int IPF_DW   = 16;
    localparam int IPF_AW   = 4;
    localparam int IPF_NREG = 4;
    localparam int IPF_NSRC = 26;
    localparam int IPF_NLVL = 4;
    localparam int IPF_IW   = 5;

    // word offsets inside the controller's register block
    localparam logic [IPF_AW-1:0] IPF_OFS_LEVELS_ZERO  = 4'h0;
    localparam logic [IPF_AW-1:0] IPF_OFS_LEVELS_ONE   = 4'h1;
    localparam logic [IPF_AW-1:0] IPF_OFS_LEVELS_TWO   = 4'h2;
    localparam logic [IPF_AW-1:0] IPF_OFS_LEVELS_THREE = 4'h3;
    localparam logic [IPF_AW-1:0] IPF_OFS [IPF_NREG] = '{
        IPF_OFS_LEVELS_ZERO, IPF_OFS_LEVELS_ONE,
        IPF_OFS_LEVELS_TWO,  IPF_OFS_LEVELS_THREE};

    // implemented bits per register; the rest are reserved and read zero
    localparam logic [IPF_DW-1:0] IPF_WMASK [IPF_NREG] = '{
        16'hC3FF, 16'hFCFF, 16'hF3FF, 16'hFFF0};
    localparam logic [IPF_DW-1:0] IPF_RST_LEVELS = 16'h0000;
    localparam logic [IPF_DW-1:0] IPF_RD_UNMAPPED = 16'h0000;
    localparam logic [1:0]        IPF_CODE_OFF   = 2'h0;

    // source number: index into these tables, 0 is the most urgent
    localparam logic [1:0] IPF_SRC_REG [IPF_NSRC] = '{
        2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0,
        2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1,
        2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2,
        2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3};
    // low bit of each two-bit level field
    localparam int IPF_SRC_LSB [IPF_NSRC] = '{
        14, 8, 6, 4, 2, 0,          // low voltage, debug rx/tx/trace/bkpt/step
        14, 12, 10, 6, 4, 2, 0,     // port b/c/d, flash x3, clock loop
        14, 12, 8, 6, 4, 2, 0,      // serial x4, spi x2, port a
        14, 12, 10, 8, 6, 4};       // converter, timers 3..0, i2c address
    // debug sources use the 1..3 level encoding
    localparam logic IPF_SRC_DBG [IPF_NSRC] = '{
        1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1,
        1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
        1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
        1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};

    localparam int IPF_SRC_LOW_VOLTAGE = 0;
    localparam int IPF_SRC_DEBUG_RX    = 1;
    localparam int IPF_SRC_CLOCK_LOOP  = 12;
    localparam int IPF_SRC_PORT_A      = 19;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [IPF_AW-1:0] addr;
        logic [IPF_DW-1:0] wdata;
    } ipf_bus_req_t;

    typedef struct packed {
        logic              valid;
        logic [IPF_IW-1:0] src;
    } ipf_win_t;

endpackage : ipf_pkg

`default_nettype wire

//--- core/ipf_priority_bank.sv
// Functional notes
// R1: debug receive-full level sits in register zero bits 9-8, levels 1-3.
// R2: debug transmit-empty level sits in register zero bits 7-6, levels 1-3.
// R3: debug trace-buffer level sits in register zero bits 5-4, levels 1-3.
// R4: debug breakpoint level sits in register zero bits 3-2, levels 1-3.
// R5: debug step-counter level sits in register zero bits 1-0, levels 1-3.
// R6: debug field codes: 00 off, 01 level 1, 10 level 2, 11 level 3.
// R7: peripheral field codes: 00 off, 01 level 0, 10 level 1, 11 level 2.
// R8: register one holds port b, c, d levels in bits 15-14, 13-12, 11-10.
// R9: register one holds flash levels in bits 7-6, 5-4 and 3-2.
// R10: register one bits 1-0 hold the clock loop lock/reference level.
// R11: reserved bits read zero and ignore writes.
// R12: register two holds serial receive full and error levels, bits 15-12.
// R13: register two holds serial transmit idle and empty levels, bits 9-6.
// R14: register two holds spi transmit empty and receive full, bits 5-2.
// R15: register two bits 1-0 hold port a level, peripheral encoding.
// R16: every level field resets to 00, so every source starts disabled.
// R17: register three is sixteen bits, resets zero, low four bits read zero.
// R18: at equal level the lowest active source number wins.
// R19: register zero bits 15-14 hold low-voltage level, levels 0-2.
// R20: a disabled source never reaches arbitration, whatever its request.
`timescale 1ns/1ns
`default_nettype none

module ipf_priority_bank
    import ipf_pkg::*;
(
    input  wire logic                        ref_clk,
    input  wire logic                        nrst,
    input  wire ipf_bus_req_t                bus_req,
    output logic     [IPF_DW-1:0]            bus_rdata_q,
    output logic                             bus_ack_q,
    input  wire logic [IPF_NSRC-1:0]         irq_req,
    output logic     [IPF_NSRC-1:0]          src_enabled_q,
    output logic     [IPF_NSRC-1:0][1:0]     src_level_q,
    output logic     [IPF_NLVL-1:0]          lvl_pending_q,
    output ipf_win_t [IPF_NLVL-1:0]          lvl_win_q
);

    logic [IPF_NREG-1:0][IPF_DW-1:0] regs_q;
    logic [IPF_NREG-1:0][IPF_DW-1:0] regs_d;
    logic [IPF_NREG-1:0]             wr_sel;
    logic                            rd_hit;
    logic [IPF_DW-1:0]               rd_data;

    logic [IPF_NSRC-1:0][1:0]        src_code;
    logic [IPF_NSRC-1:0][1:0]        src_lvl;
    logic [IPF_NSRC-1:0]             src_en;
    logic [IPF_NSRC-1:0]             src_act;
    logic [IPF_NLVL-1:0][IPF_NSRC-1:0] lvl_req;
    ipf_win_t [IPF_NLVL-1:0]         lvl_win;

    // lowest set bit; the loop runs downward so the smallest index is last
    function automatic ipf_win_t ipf_lowest(
        input logic [IPF_NSRC-1:0] v
    );
        ipf_win_t w;
        w = '0;
        for (int i = IPF_NSRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                w.valid = 1'b1;
                w.src   = IPF_IW'(i);
            end
        end
        return w;
    endfunction : ipf_lowest

    // register access
    genvar r;
    generate
        for (r = 0; r < IPF_NREG; r++) begin : g_reg
            assign wr_sel[r] = bus_req.wr && (bus_req.addr == IPF_OFS[r]);
            // reserved bits are masked off, so they neither store nor read
            assign regs_d[r] = bus_req.wdata & IPF_WMASK[r]; // R11 R17
        end
    endgenerate

    assign rd_hit  = bus_req.addr <= IPF_OFS_LEVELS_THREE;
    assign rd_data = rd_hit ? regs_q[bus_req.addr[1:0]] : IPF_RD_UNMAPPED;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < IPF_NREG; i++) begin
                regs_q[i] <= IPF_RST_LEVELS; // R16 R17
            end
        end else begin
            for (int i = 0; i < IPF_NREG; i++) begin
                if (wr_sel[i]) begin
                    regs_q[i] <= regs_d[i];
                end
            end
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            bus_rdata_q <= IPF_RD_UNMAPPED;
            bus_ack_q   <= 1'b0;
        end else begin
            bus_ack_q <= bus_req.rd;
            if (bus_req.rd) begin
                bus_rdata_q <= rd_data;
            end
        end
    end

    // per-source field decode
    genvar s;
    generate
        for (s = 0; s < IPF_NSRC; s++) begin : g_src
            // field placement comes from the source table
            assign src_code[s] =
                regs_q[IPF_SRC_REG[s]][IPF_SRC_LSB[s] +: 2]; // R1 R2 R3 R4 R5 R8 R9 R10 R12 R13 R14 R15 R19
            assign src_en[s]   = src_code[s] != IPF_CODE_OFF;
            // debug codes map straight to level; peripherals sit one lower
            assign src_lvl[s]  = IPF_SRC_DBG[s] ? src_code[s]
                                                : src_code[s] - 2'h1; // R6 R7
            // the off code gates the request line itself
            assign src_act[s]  = src_en[s] && irq_req[s]; // R20
        end
    endgenerate

    genvar l;
    generate
        for (l = 0; l < IPF_NLVL; l++) begin : g_lvl
            for (s = 0; s < IPF_NSRC; s++) begin : g_pick
                assign lvl_req[l][s] = src_act[s] && (src_lvl[s] == 2'(l));
            end
            assign lvl_win[l] = ipf_lowest(lvl_req[l]); // R18
        end
    endgenerate

    // outputs are registered, so arbitration sees a one-cycle delay
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            src_enabled_q <= '0;
            src_level_q   <= '0;
            lvl_pending_q <= '0;
            lvl_win_q     <= '0;
        end else begin
            src_enabled_q <= src_en;
            src_level_q   <= src_lvl;
            for (int i = 0; i < IPF_NLVL; i++) begin
                lvl_pending_q[i] <= lvl_win[i].valid;
                lvl_win_q[i]     <= lvl_win[i];
            end
        end
    end

    // checks
    logic                              wr_seen_q;
    // requests one cycle back, lined up with the registered winners
    logic [IPF_NLVL-1:0][IPF_NSRC-1:0] lvl_req_q;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            wr_seen_q <= 1'b0;
        end else if (bus_req.wr) begin
            wr_seen_q <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            lvl_req_q <= '0;
        end else begin
            lvl_req_q <= lvl_req;
        end
    end

    AST_RESET_DISABLED: // R16
    assert property (@(posedge ref_clk) disable iff (!nrst)
        !wr_seen_q |-> (regs_q == '0) && (src_enabled_q == '0))
    else $error("level field left reset value without a write");

    AST_RESERVED_ONE: // R11
    assert property (@(posedge ref_clk) disable iff (!nrst)
        (regs_q[1][9:8] == 2'h0) && (regs_q[2][11:10] == 2'h0)
        && (regs_q[0][13:10] == 4'h0))
    else $error("reserved bits hold a nonzero value");

    AST_LOW_NIBBLE_THREE: // R17
    assert property (@(posedge ref_clk) disable iff (!nrst)
        (bus_req.rd && bus_req.addr == IPF_OFS_LEVELS_THREE)
        |=> bus_ack_q && (bus_rdata_q[3:0] == 4'h0))
    else $error("register three low bits did not read zero");

    AST_WRITE_ZERO: // R1
    assert property (@(posedge ref_clk) disable iff (!nrst)
        (bus_req.wr && bus_req.addr == IPF_OFS_LEVELS_ZERO)
        |=> regs_q[0] == ($past(bus_req.wdata) & 16'hC3FF))
    else $error("register zero write not stored under its mask");

    AST_WRITE_TWO: // R12
    assert property (@(posedge ref_clk) disable iff (!nrst)
        (bus_req.wr && bus_req.addr == IPF_OFS_LEVELS_TWO)
        ##1 (bus_req.rd && bus_req.addr == IPF_OFS_LEVELS_TWO
             && !bus_req.wr)
        |=> bus_rdata_q == ($past(bus_req.wdata, 2) & 16'hF3FF))
    else $error("register two read back differs from written value");

    AST_DEBUG_LEVEL: // R6
    assert property (@(posedge ref_clk) disable iff (!nrst)
        (regs_q[0][9:8] != 2'h0)
        |=> src_level_q[IPF_SRC_DEBUG_RX] == $past(regs_q[0][9:8]))
    else $error("debug source level is not its code");

    AST_PERIPH_LEVEL: // R7
    assert property (@(posedge ref_clk) disable iff (!nrst)
        (regs_q[2][1:0] != 2'h0)
        |=> src_level_q[IPF_SRC_PORT_A] == $past(regs_q[2][1:0]) - 2'h1)
    else $error("peripheral source level is not code minus one");

    AST_LOW_VOLTAGE: // R19
    assert property (@(posedge ref_clk) disable iff (!nrst)
        (regs_q[0][15:14] == 2'h3) && irq_req[IPF_SRC_LOW_VOLTAGE]
        |=> lvl_win_q[2].valid
            && (lvl_win_q[2].src == IPF_IW'(IPF_SRC_LOW_VOLTAGE)))
    else $error("low voltage source escaped its level range");

    AST_DISABLED_HIDDEN: // R20
    assert property (@(posedge ref_clk) disable iff (!nrst)
        (regs_q[1][1:0] == 2'h0)
        |=> !src_enabled_q[IPF_SRC_CLOCK_LOOP]
            && (lvl_win_q[0].src != IPF_IW'(IPF_SRC_CLOCK_LOOP)
                || !lvl_win_q[0].valid)
            && (lvl_win_q[3].src != IPF_IW'(IPF_SRC_CLOCK_LOOP)
                || !lvl_win_q[3].valid))
    else $error("disabled clock loop source was presented");

    AST_WINNER_ENABLED: // R20
    assert property (@(posedge ref_clk) disable iff (!nrst)
        lvl_win_q[1].valid |-> src_enabled_q[lvl_win_q[1].src])
    else $error("winner at level one is a disabled source");

    AST_LOWEST_WINS: // R18
    assert property (@(posedge ref_clk) disable iff (!nrst)
        lvl_win_q[0].valid
        |-> lvl_req_q[0][lvl_win_q[0].src]
            && ((lvl_req_q[0]
                 & ((26'h000_0001 << lvl_win_q[0].src) - 26'h000_0001))
                == '0))
    else $error("level zero winner is not the lowest active source");

    AST_LOWEST_WINS_ONE: // R18
    assert property (@(posedge ref_clk) disable iff (!nrst)
        lvl_win_q[1].valid
        |-> lvl_req_q[1][lvl_win_q[1].src]
            && ((lvl_req_q[1]
                 & ((26'h000_0001 << lvl_win_q[1].src) - 26'h000_0001))
                == '0))
    else $error("level one winner is not the lowest active source");

    AST_READ_ANSWER: // R11
    assert property (@(posedge ref_clk) disable iff (!nrst)
        (bus_req.rd && bus_req.addr > IPF_OFS_LEVELS_THREE)
        |=> bus_ack_q && (bus_rdata_q == 16'h0000))
    else $error("unmapped offset did not read zero");

    AST_WRITE_ONE: // R11
    assert property (@(posedge ref_clk) disable iff (!nrst)
        (bus_req.wr && bus_req.addr == IPF_OFS_LEVELS_ONE)
        |=> regs_q[1] == ($past(bus_req.wdata) & 16'hFCFF))
    else $error("register one write not stored under its mask");

    AST_UNMAPPED_WRITE: // R11
    assert property (@(posedge ref_clk) disable iff (!nrst)
        (bus_req.wr && bus_req.addr > IPF_OFS_LEVELS_THREE)
        |=> regs_q == $past(regs_q))
    else $error("write to an unmapped offset changed a register");

    AST_DEBUG_TX_FIELD: // R2
    assert property (@(posedge ref_clk) disable iff (!nrst)
        (regs_q[0][7:6] != 2'h0)
        |=> src_enabled_q[2] && (src_level_q[2] == $past(regs_q[0][7:6])))
    else $error("debug transmit level not taken from bits 7-6");

    AST_DEBUG_TRACE_FIELD: // R3
    assert property (@(posedge ref_clk) disable iff (!nrst)
        (regs_q[0][5:4] != 2'h0)
        |=> src_enabled_q[3] && (src_level_q[3] == $past(regs_q[0][5:4])))
    else $error("debug trace level not taken from bits 5-4");

    AST_DEBUG_BREAK_FIELD: // R4
    assert property (@(posedge ref_clk) disable iff (!nrst)
        (regs_q[0][3:2] != 2'h0)
        |=> src_enabled_q[4] && (src_level_q[4] == $past(regs_q[0][3:2])))
    else $error("debug breakpoint level not taken from bits 3-2");

    AST_DEBUG_STEP_FIELD: // R5
    assert property (@(posedge ref_clk) disable iff (!nrst)
        (regs_q[0][1:0] != 2'h0)
        |=> src_enabled_q[5] && (src_level_q[5] == $past(regs_q[0][1:0])))
    else $error("debug step level not taken from bits 1-0");

    AST_PORT_FIELDS: // R8
    assert property (@(posedge ref_clk) disable iff (!nrst)
        src_enabled_q[8:6] == {($past(regs_q[1][11:10]) != 2'h0),
                               ($past(regs_q[1][13:12]) != 2'h0),
                               ($past(regs_q[1][15:14]) != 2'h0)})
    else $error("port level fields misplaced in register one");

    AST_FLASH_FIELDS: // R9
    assert property (@(posedge ref_clk) disable iff (!nrst)
        src_enabled_q[11:9] == {($past(regs_q[1][3:2]) != 2'h0),
                                ($past(regs_q[1][5:4]) != 2'h0),
                                ($past(regs_q[1][7:6]) != 2'h0)})
    else $error("flash level fields misplaced in register one");

    AST_CLOCK_LOOP_FIELD: // R10
    assert property (@(posedge ref_clk) disable iff (!nrst)
        (regs_q[1][1:0] != 2'h0)
        |=> src_enabled_q[12]
            && (src_level_q[12] == $past(regs_q[1][1:0]) - 2'h1))
    else $error("clock loop level not taken from bits 1-0");

    AST_SERIAL_RX_FIELDS: // R12
    assert property (@(posedge ref_clk) disable iff (!nrst)
        src_enabled_q[14:13] == {($past(regs_q[2][13:12]) != 2'h0),
                                 ($past(regs_q[2][15:14]) != 2'h0)})
    else $error("serial receive fields misplaced in register two");

    AST_SERIAL_TX_FIELDS: // R13
    assert property (@(posedge ref_clk) disable iff (!nrst)
        src_enabled_q[16:15] == {($past(regs_q[2][7:6]) != 2'h0),
                                 ($past(regs_q[2][9:8]) != 2'h0)})
    else $error("serial transmit fields misplaced in register two");

    AST_SPI_FIELDS: // R14
    assert property (@(posedge ref_clk) disable iff (!nrst)
        src_enabled_q[18:17] == {($past(regs_q[2][3:2]) != 2'h0),
                                 ($past(regs_q[2][5:4]) != 2'h0)})
    else $error("spi fields misplaced in register two");

    AST_THREE_FIELDS: // R17
    assert property (@(posedge ref_clk) disable iff (!nrst)
        src_enabled_q[25:20] == {($past(regs_q[3][5:4]) != 2'h0),
                                 ($past(regs_q[3][7:6]) != 2'h0),
                                 ($past(regs_q[3][9:8]) != 2'h0),
                                 ($past(regs_q[3][11:10]) != 2'h0),
                                 ($past(regs_q[3][13:12]) != 2'h0),
                                 ($past(regs_q[3][15:14]) != 2'h0)})
    else $error("register three fields misplaced");

    AST_NO_PERIPH_LEVEL_THREE: // R7
    assert property (@(posedge ref_clk) disable iff (!nrst)
        lvl_win_q[3].valid
        |-> lvl_win_q[3].src inside {[5'h01:5'h05]})
    else $error("a peripheral source reached level three");

endmodule : ipf_priority_bank

`default_nettype wire

//--- test/ipf_irq_src_model.sv
`timescale 1ns/1ns
`default_nettype none

module ipf_irq_src_model
    import ipf_pkg::*;
(
    input  wire logic                ref_clk,
    input  wire logic                nrst,
    input  wire logic [IPF_NSRC-1:0] raise,
    output logic      [IPF_NSRC-1:0] irq_req
);
    // peripherals launch level requests from their own flops, one edge late
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            irq_req <= '0;
        end else begin
            irq_req <= raise;
        end
    end
endmodule : ipf_irq_src_model

`default_nettype wire

//--- test/interrupt_priority_fields_test.sv
`timescale 1ns/1ns
`default_nettype none

module interrupt_priority_fields_test;
    import ipf_pkg::*;
    logic                      ref_clk = 1'b0;
    logic                      nrst    = 1'b0;
    ipf_bus_req_t              bus_req = '0;
    logic [IPF_DW-1:0]         bus_rdata_q;
    logic                      bus_ack_q;
    logic [IPF_NSRC-1:0]       raise   = '0;
    logic [IPF_NSRC-1:0]       irq_req;
    logic [IPF_NSRC-1:0]       src_enabled_q;
    logic [IPF_NSRC-1:0][1:0]  src_level_q;
    logic [IPF_NLVL-1:0]       lvl_pending_q;
    ipf_win_t [IPF_NLVL-1:0]   lvl_win_q;
    int                        fail_count = 0;
    int                        checks     = 0;
    int                        lvl;
    int                        lsb [26] = '{14, 8, 6, 4, 2, 0, 14, 12, 10, 6,
        4, 2, 0, 14, 12, 8, 6, 4, 2, 0, 14, 12, 10, 8, 6, 4};
    logic [15:0]               mask [4] = '{16'hC3FF, 16'hFCFF, 16'hF3FF,
        16'hFFF0};
    logic [15:0]               pat [2] = '{16'hFFFF, 16'hA5A5};

    always #4 ref_clk = ~ref_clk;

    ipf_priority_bank dut (
        .ref_clk(ref_clk), .nrst(nrst), .bus_req(bus_req),
        .bus_rdata_q(bus_rdata_q), .bus_ack_q(bus_ack_q),
        .irq_req(irq_req), .src_enabled_q(src_enabled_q),
        .src_level_q(src_level_q), .lvl_pending_q(lvl_pending_q),
        .lvl_win_q(lvl_win_q));

    ipf_irq_src_model srcs (
        .ref_clk(ref_clk), .nrst(nrst), .raise(raise), .irq_req(irq_req));

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wr_reg(input int a, input logic [15:0] d);
        @(posedge ref_clk);
        bus_req <= '{wr: 1'b1, rd: 1'b0, addr: IPF_AW'(a), wdata: d};
        @(posedge ref_clk);
        bus_req.wr <= 1'b0;
    endtask : wr_reg

    // read answer is one cycle after the strobe and the ack lasts one cycle
    task automatic rd_reg(input int a, input logic [15:0] exp);
        @(posedge ref_clk);
        bus_req <= '{wr: 1'b0, rd: 1'b1, addr: IPF_AW'(a), wdata: 16'h0000};
        @(posedge ref_clk);
        bus_req.rd <= 1'b0;
        #1;
        check("ack", 32'(bus_ack_q), 32'h0000_0001);
        check("rdata", 32'(bus_rdata_q), 32'(exp));
        @(posedge ref_clk);
        #1;
        check("ack_end", 32'(bus_ack_q), 32'h0000_0000);
    endtask : rd_reg

    // write then read the same offset at the next edge, no idle cycle
    task automatic wr_then_rd(input int a, input logic [15:0] d,
                              input logic [15:0] exp);
        @(posedge ref_clk);
        bus_req <= '{wr: 1'b1, rd: 1'b0, addr: IPF_AW'(a), wdata: d};
        @(posedge ref_clk);
        bus_req <= '{wr: 1'b0, rd: 1'b1, addr: IPF_AW'(a), wdata: d};
        @(posedge ref_clk);
        bus_req.rd <= 1'b0;
        #1;
        check("ack_b2b", 32'(bus_ack_q), 32'h0000_0001);
        check("rdata_b2b", 32'(bus_rdata_q), 32'(exp));
    endtask : wr_then_rd

    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : settle

    task automatic close_out();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out

    initial begin
        #100000;
        fail_count++;
        close_out();
    end

    initial begin
        repeat (12) @(posedge ref_clk);
        nrst <= 1'b1;
        for (int r = 0; r < 4; r++) rd_reg(r, 16'h0000);
        @(posedge ref_clk);
        raise <= '1;
        settle(3);
        check("enabled", 32'(src_enabled_q), 32'h0000_0000);
        check("pending", 32'(lvl_pending_q), 32'h0000_0000);
        for (int p = 0; p < 2; p++) begin
            for (int r = 0; r < 16; r++) begin
                wr_reg(r, pat[p]);
                rd_reg(r, r < 4 ? pat[p] & mask[r] : 16'h0000);
            end
        end
        wr_then_rd(2, 16'hFFFF, 16'hF3FF);
        wr_then_rd(3, 16'hFFFF, 16'hFFF0);
        // every source alone, every non-off code, all requests high
        for (int s = 0; s < IPF_NSRC; s++) begin
            for (int c = 1; c < 4; c++) begin
                lvl = (s >= 1 && s <= 5) ? c : c - 1;
                for (int r = 0; r < 4; r++) begin
                    wr_reg(r, r == (s < 6 ? 0 : s < 13 ? 1 : s < 20 ? 2 : 3)
                        ? 16'(c) << lsb[s] : 16'h0000);
                end
                settle(1);
                check("enabled", 32'(src_enabled_q), 32'(1) << s);
                check("level", 32'(src_level_q[s]), 32'(lvl));
                check("pending", 32'(lvl_pending_q), 32'(1) << lvl);
                check("winner", 32'(lvl_win_q[lvl]), {26'h0, 1'b1, 5'(s)});
            end
        end
        // three sources tied at level one; winner moves as requests drop
        wr_reg(0, 16'h0050);
        wr_reg(1, 16'h8000);
        wr_reg(2, 16'h0000);
        wr_reg(3, 16'h0000);
        settle(1);
        check("winner", 32'(lvl_win_q[1]), 32'h0000_0022);
        @(posedge ref_clk);
        raise <= ~(26'(1) << 2);
        settle(3);
        check("winner", 32'(lvl_win_q[1]), 32'h0000_0023);
        @(posedge ref_clk);
        raise <= ~(26'(3) << 2);
        settle(3);
        check("winner", 32'(lvl_win_q[1]), 32'h0000_0026);
        check("pending", 32'(lvl_pending_q), 32'h0000_0002);
        // a second reset in mid-run must clear every field again
        @(posedge ref_clk);
        nrst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        settle(1);
        check("enabled_rst", 32'(src_enabled_q), 32'h0000_0000);
        check("pending_rst", 32'(lvl_pending_q), 32'h0000_0000);
        for (int r = 0; r < 4; r++) rd_reg(r, 16'h0000);
        close_out();
    end
endmodule : interrupt_priority_fields_test

`default_nettype wire
